/* File: rtl/nn_mac_pkg.sv */
// Shared constants and types for the neural MAC array.
// Assumes APB register access and a wide operand port from the wrapper.
package nn_mac_pkg;
    localparam int GRID_N = 16;
    localparam int ELEM_W = 16;
    localparam int DEF_EXP_W = 8;
    localparam int DEF_MAN_W = 7;
    localparam int DEF_SHELL_W = 512;
    localparam int DEF_MAC_LAT = 2;
    localparam int DEF_N_INST = 1;
    localparam int ROW_BITS = GRID_N * ELEM_W;
    // APB byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CONFIG = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_VALID = 12'h00c;
    localparam logic [11:0] ADDR_OUT_BASE = 12'h040;
    localparam logic [11:0] OUT_STRIDE = 12'h020;
    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CFG_COLS_LSB = 0;
    localparam int CFG_ROWS_LSB = 4;
    localparam int CFG_ACT_BIT = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_SAT_BIT = 2;
    // Wrapper port beat indices; weights use 0 up to the row-group count
    localparam logic [4:0] SH_IDX_INPUT = 5'h10;
    localparam logic [4:0] SH_IDX_BIAS = 5'h11;
    typedef struct packed {
        logic act_relu;
        logic [3:0] rows_m1;
        logic [3:0] cols_m1;
    } cfg_type;
    localparam cfg_type CFG_RESET = 9'h0ff;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } state_type;
endpackage

/* File: rtl/nn_mac_cell.sv */
// One fused multiply-accumulate cell: acc_out = w * x + acc_in, pipelined.
// Assumes operands are held stable by the array control during a pass.
`timescale 1ns/1ps
`default_nettype none
module nn_mac_cell
#(
    parameter int EXP_W = 8,
    parameter int MAN_W = 7,
    parameter int LAT = 2,
    localparam int W = 1 + EXP_W + MAN_W
)
(
    input wire logic i_clk, // Core clock
    input wire logic i_rst, // Synchronous reset
    input wire logic i_en, // Column in use
    input wire logic i_sat, // Saturation from left neighbour
    input wire logic [W-1:0] i_w, // Weight
    input wire logic [W-1:0] i_x, // Input element
    input wire logic [W-1:0] i_acc, // Partial sum in
    output logic [W-1:0] o_acc, // Partial sum out
    output logic o_sat // Saturation seen so far
);
    localparam int M = MAN_W + 1;
    localparam int SW = 2 * M + 2;
    localparam int BIAS = (1 << (EXP_W - 1)) - 1;
    localparam int EMAX = (1 << EXP_W) - 2;

    logic [W-1:0] res;
    logic res_sat;
    logic [LAT-1:0][W-1:0] pipe_r;
    logic [LAT-1:0] sat_r;

    always_comb
    begin
        int ea, eb, ec, ep, el, ediff, lead, er;
        logic [SW-1:0] ap, ac, big, sml, sum, norm;
        logic sp, sc, sr;
        ea = int'(i_w[W-2 -: EXP_W]);
        eb = int'(i_x[W-2 -: EXP_W]);
        ec = int'(i_acc[W-2 -: EXP_W]);
        sp = i_w[W-1] ^ i_x[W-1];
        sc = i_acc[W-1];
        ep = ea + eb - BIAS;
        ap = (ea == 0 || eb == 0) ? '0 :
            SW'({1'b1, i_w[MAN_W-1:0]}) * SW'({1'b1, i_x[MAN_W-1:0]});
        ac = (ec == 0) ? '0 : SW'({1'b1, i_acc[MAN_W-1:0]}) << MAN_W;
        big = ap;
        sml = ac;
        el = ep;
        sr = sp;
        ediff = ep - ec;
        // Align the smaller operand to the larger exponent
        if (ap == '0 || (ac != '0 && ec > ep))
        begin
            big = ac;
            sml = (ap == '0) ? '0 : ap;
            el = ec;
            sr = sc;
            ediff = ec - ep;
        end
        if (ediff >= SW)
            sml = '0;
        else
            sml = sml >> ediff;
        if (sp == sc)
            sum = big + sml;
        else if (big >= sml)
            sum = big - sml;
        else
        begin
            sum = sml - big;
            sr = ~sr;
        end
        lead = 0;
        for (int i = 0; i < SW; i++)
            if (sum[i])
                lead = i;
        er = el + lead - 2 * MAN_W;
        norm = sum << (SW - 1 - lead);
        res_sat = 1'b0;
        if (!i_en)
            res = i_acc;
        else if (ea > EMAX || eb > EMAX || ec > EMAX || er > EMAX)
        begin
            res = {sr, EXP_W'(EMAX), {MAN_W{1'b1}}};
            res_sat = 1'b1;
        end
        else if (sum == '0 || er <= 0)
            res = '0;
        else
            res = {sr, EXP_W'(er), norm[SW-2 -: MAN_W]};
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pipe_r <= '0;
            sat_r <= '0;
        end
        else
        begin
            pipe_r[0] <= res;
            sat_r[0] <= res_sat | i_sat;
            for (int k = 1; k < LAT; k++)
            begin
                pipe_r[k] <= pipe_r[k-1];
                sat_r[k] <= sat_r[k-1];
            end
        end
    end

    assign o_acc = pipe_r[LAT-1];
    assign o_sat = sat_r[LAT-1];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_cell_latency: assert property (##LAT o_acc == $past(res, LAT))
        else $error("cell output not delayed by the set latency");
    a_cell_bypass: assert property (!i_en |-> ##LAT o_acc == $past(i_acc, LAT))
        else $error("unused column altered the partial sum");
endmodule
`default_nettype wire

/* File: rtl/nn_mac_array.sv */
// Neural MAC array: 16x16 grid of FMA cells per instance, APB control.
// Assumes the wrapper loads operands over the wide port and reads results.
//
// Notes on behaviour
// - Grid of cells, default 256 as 16x16.
// - Number format is a build parameter, bfloat16.
// - Wrapper port width parameter, default 512 bits.
// - MAC pipeline depth set; control timing follows.
// - Instance count parameter, default one.
// - Input vector register, sixteen elements, 32 bytes.
// - Bias vector register, sixteen elements, 32 bytes.
// - Weight matrix register, 256 elements, 512 bytes.
// - Output register holds sixteen node values.
// - One pass: 256 FMAs, up to 16 nodes.
// - Node equals weight row times input plus bias.
// - Activation applied to each accumulated node value.
// - Configuration states used rows and columns.
// - Saturation flag set when a result saturates.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module nn_mac_array
    import nn_mac_pkg::*;
#(
    parameter int EXP_W = DEF_EXP_W,
    parameter int MAN_W = DEF_MAN_W,
    parameter int SHELL_W = DEF_SHELL_W,
    parameter int MAC_LAT = DEF_MAC_LAT,
    parameter int N_INST = DEF_N_INST,
    localparam int IW = (N_INST > 1) ? $clog2(N_INST) : 1
)
(
    input wire logic I_CORE_CLK, // Core clock, 10 MHz
    input wire logic I_RST, // Synchronous reset, active high
    input wire logic I_PSEL, // APB select
    input wire logic I_PENABLE, // APB enable
    input wire logic I_PWRITE, // APB direction
    input wire logic [11:0] I_PADDR, // APB byte address
    input wire logic [31:0] I_PWDATA, // APB write data
    output logic [31:0] O_PRDATA, // APB read data
    output logic O_PREADY, // APB ready
    output logic O_PSLVERR, // APB error on unmapped address
    input wire logic I_SHELL_WE, // Operand beat strobe
    input wire logic [IW-1:0] I_SHELL_INST, // Instance of the beat or read
    input wire logic [4:0] I_SHELL_IDX, // Beat target
    input wire logic [SHELL_W-1:0] I_SHELL_DATA, // Operand beat
    output logic O_SHELL_READY, // Operand loads accepted
    output logic [ROW_BITS-1:0] O_SHELL_RDATA, // Output vector of instance
    output logic O_DONE, // Sticky pass-complete flag
    output logic O_SAT // Sticky saturation flag
);
    localparam int RPB = SHELL_W / ROW_BITS;
    localparam int PASS_CYC = GRID_N * MAC_LAT + 1;
    localparam int CW = $clog2(PASS_CYC + 1);
    localparam int OUT_WORDS = N_INST * GRID_N / 2;

    typedef logic [GRID_N-1:0][ELEM_W-1:0] vec_type;

    function automatic logic row_used(input logic [3:0] lim, input int idx);
        row_used = (idx <= int'(lim));
    endfunction

    logic [N_INST-1:0][GRID_N-1:0] [GRID_N-1:0][ELEM_W-1:0] weight_r;
    vec_type [N_INST-1:0] in_r;
    vec_type [N_INST-1:0] bias_r;
    vec_type [N_INST-1:0] out_r;
    cfg_type cfg_r;
    state_type state_r;
    logic [CW-1:0] cnt_r;
    logic done_r;
    logic sat_r;
    logic [GRID_N-1:0] valid_r;
    logic apb_ack_r;
    logic [31:0] prdata_r;
    logic slverr_r;
    logic shell_rdy_r;
    logic [ROW_BITS-1:0] shell_rd_r;

    // Grid partial-sum and saturation chains
    logic [N_INST-1:0][GRID_N-1:0][GRID_N:0][ELEM_W-1:0] chain;
    logic [N_INST-1:0][GRID_N-1:0][GRID_N:0] sat_chain;

    genvar gi, gr, gc;
    generate
        for (gi = 0; gi < N_INST; gi++)
        begin : g_inst
            for (gr = 0; gr < GRID_N; gr++)
            begin : g_row
                assign chain[gi][gr][0] = bias_r[gi][gr];
                assign sat_chain[gi][gr][0] = 1'b0;
                for (gc = 0; gc < GRID_N; gc++)
                begin : g_col
                    nn_mac_cell #(
                        .EXP_W(EXP_W),
                        .MAN_W(MAN_W),
                        .LAT(MAC_LAT)
                    ) u_cell (
                        .i_clk(I_CORE_CLK),
                        .i_rst(I_RST),
                        .i_en(gc <= int'(cfg_r.cols_m1)),
                        .i_sat(sat_chain[gi][gr][gc]),
                        .i_w(weight_r[gi][gr][gc]),
                        .i_x(in_r[gi][gc]),
                        .i_acc(chain[gi][gr][gc]),
                        .o_acc(chain[gi][gr][gc+1]),
                        .o_sat(sat_chain[gi][gr][gc+1])
                    );
                end
            end
        end
    endgenerate

    // APB decode
    wire apb_acc = I_PSEL && I_PENABLE;
    wire apb_wr = apb_acc && apb_ack_r && I_PWRITE;
    wire hit_ctrl = (I_PADDR == ADDR_CTRL);
    wire hit_cfg = (I_PADDR == ADDR_CONFIG);
    wire hit_stat = (I_PADDR == ADDR_STATUS);
    wire hit_valid = (I_PADDR == ADDR_VALID);
    wire [11:0] out_off = I_PADDR - ADDR_OUT_BASE;
    wire hit_out = (I_PADDR >= ADDR_OUT_BASE) && (I_PADDR[1:0] == 2'b00)
        && (int'(out_off[11:2]) < OUT_WORDS);
    wire hit_any = hit_ctrl || hit_cfg || hit_stat || hit_valid || hit_out;
    wire [N_INST*ROW_BITS-1:0] out_flat = out_r;
    wire busy = (state_r == ST_RUN);
    wire start = apb_wr && hit_ctrl && I_PWDATA[CTRL_START_BIT] && !busy;
    wire finish = busy && (cnt_r == '0);
    wire clr_done = apb_wr && hit_stat && I_PWDATA[STAT_DONE_BIT];
    wire clr_sat = apb_wr && hit_stat && I_PWDATA[STAT_SAT_BIT];
    wire shell_ok = I_SHELL_WE && !busy;

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        if (hit_cfg)
            rd_mux = 32'(cfg_r);
        else if (hit_stat)
            rd_mux = 32'({sat_r, done_r, busy});
        else if (hit_valid)
            rd_mux = 32'(valid_r);
        else if (hit_out)
            rd_mux = out_flat[32*int'(out_off[11:2]) +: 32];
    end

    // Results at capture: activation and row masking
    vec_type [N_INST-1:0] result;
    logic [N_INST-1:0] inst_sat;
    always_comb
    begin
        for (int i = 0; i < N_INST; i++)
        begin
            inst_sat[i] = 1'b0;
            for (int r = 0; r < GRID_N; r++)
            begin
                result[i][r] = chain[i][r][GRID_N];
                if (cfg_r.act_relu && result[i][r][ELEM_W-1])
                    result[i][r] = '0;
                if (!row_used(cfg_r.rows_m1, r))
                    result[i][r] = '0;
                else
                    inst_sat[i] = inst_sat[i] | sat_chain[i][r][GRID_N];
            end
        end
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
        begin
            apb_ack_r <= 1'b0;
            prdata_r <= '0;
            slverr_r <= 1'b0;
        end
        else
        begin
            apb_ack_r <= apb_acc && !apb_ack_r;
            prdata_r <= (apb_acc && !apb_ack_r && !I_PWRITE) ? rd_mux : '0;
            slverr_r <= apb_acc && !apb_ack_r && !hit_any;
        end
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            cfg_r <= CFG_RESET;
        end
        else
        begin
            if (apb_wr && hit_cfg && !busy)
                cfg_r <= cfg_type'(I_PWDATA[8:0]);
            case (state_r)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_r <= ST_RUN;
                        cnt_r <= CW'(PASS_CYC - 1);
                    end
                end
                ST_RUN:
                begin
                    if (cnt_r == '0)
                        state_r <= ST_IDLE;
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
        begin
            done_r <= 1'b0;
            sat_r <= 1'b0;
            valid_r <= '0;
            out_r <= '0;
        end
        else
        begin
            // Set wins over a clear in the same cycle
            done_r <= finish || (done_r && !clr_done);
            sat_r <= (finish && |inst_sat) || (sat_r && !clr_sat);
            if (finish)
            begin
                out_r <= result;
                for (int r = 0; r < GRID_N; r++)
                    valid_r[r] <= row_used(cfg_r.rows_m1, r);
            end
            else if (start)
                valid_r <= '0;
        end
    end

    // Operand loads from the wrapper, refused while a pass runs
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
        begin
            weight_r <= '0;
            in_r <= '0;
            bias_r <= '0;
            shell_rdy_r <= 1'b0;
            shell_rd_r <= '0;
        end
        else
        begin
            shell_rdy_r <= !busy && !start;
            shell_rd_r <= out_r[I_SHELL_INST];
            if (shell_ok && I_SHELL_IDX == SH_IDX_INPUT)
                in_r[I_SHELL_INST] <= I_SHELL_DATA[ROW_BITS-1:0];
            if (shell_ok && I_SHELL_IDX == SH_IDX_BIAS)
                bias_r[I_SHELL_INST] <= I_SHELL_DATA[ROW_BITS-1:0];
            for (int b = 0; b < RPB; b++)
                if (shell_ok && int'(I_SHELL_IDX) * RPB + b < GRID_N)
                    weight_r[I_SHELL_INST][int'(I_SHELL_IDX) * RPB + b] <=
                        I_SHELL_DATA[b*ROW_BITS +: ROW_BITS];
        end
    end

    assign O_PRDATA = prdata_r;
    assign O_PREADY = apb_ack_r;
    assign O_PSLVERR = slverr_r;
    assign O_SHELL_READY = shell_rdy_r;
    assign O_SHELL_RDATA = shell_rd_r;
    assign O_DONE = done_r;
    assign O_SAT = sat_r;

    // Helper: cycles spent in the current pass
    logic [CW-1:0] run_len;
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST || start)
            run_len <= '0;
        else if (busy)
            run_len <= run_len + 1'b1;
    end

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    a_pass_length: assert property (finish |-> run_len == CW'(PASS_CYC - 1))
        else $error("pass did not last the pipeline latency");
    a_start_busy: assert property (start |=> busy ##1 busy)
        else $error("start did not begin a pass");
    a_weight_hold: assert property (busy |=> $stable(weight_r))
        else $error("weights changed during a pass");
    a_input_hold: assert property (busy |=> $stable(in_r) && $stable(bias_r))
        else $error("input or bias changed during a pass");
    a_cfg_hold: assert property (busy |=> $stable(cfg_r))
        else $error("configuration changed during a pass");
    a_done_set: assert property (finish |=> O_DONE && !busy && out_r == $past(result))
        else $error("results not captured at pass end");
    a_sat_flag: assert property (finish && |inst_sat |=> O_SAT)
        else $error("saturation not flagged");
    a_unused_rows: assert property (finish |=> (valid_r[GRID_N-1] ||
        out_r[0][GRID_N-1] == '0))
        else $error("unused row reported a value");
    a_relu_out: assert property (finish && cfg_r.act_relu |=>
        !out_r[0][0][ELEM_W-1])
        else $error("activation left a negative node");
    a_apb_answer: assert property (apb_acc && !apb_ack_r |=> O_PREADY ##1 !O_PREADY)
        else $error("APB answer not given in one wait cycle");
endmodule
`default_nettype wire

/* File: bench/shell_engine.sv */
// Wrapper-side operand mover: loads operand beats and fetches output vectors.
// Assumes one array instance and a beat taken at the edge where ready is high.
`timescale 1ns/1ps
`default_nettype none
module shell_engine
    import nn_mac_pkg::*;
(
    input wire logic i_clk, // Core clock
    input wire logic i_ready, // Array accepts beats
    input wire logic [ROW_BITS-1:0] i_rdata, // Output vector of selected instance
    output logic o_we, // Beat strobe
    output logic [0:0] o_inst, // Instance select
    output logic [4:0] o_idx, // Beat target
    output logic [DEF_SHELL_W-1:0] o_data, // Beat data
    output logic o_tmo // A wait ran out
);
    initial
    begin
        o_we = 1'b0;
        o_inst = 1'b0;
        o_idx = 5'h1f;
        o_data = '0;
        o_tmo = 1'b0;
    end

    // Released lines show the inverse of the last beat, never a stale copy
    task automatic load(input logic [4:0] idx, input logic [DEF_SHELL_W-1:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        while (i_ready !== 1'b1 && n < 100)
        begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 100)
            o_tmo = 1'b1;
        o_we <= 1'b1;
        o_idx <= idx;
        o_data <= d;
        @(posedge i_clk);
        o_we <= 1'b0;
        o_idx <= ~idx;
        o_data <= ~d;
    endtask

    task automatic fetch(input logic [0:0] inst, output logic [ROW_BITS-1:0] v);
        @(posedge i_clk);
        o_inst <= inst;
        repeat (2) @(posedge i_clk);
        v = i_rdata;
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the neural MAC array: APB control plus wrapper beats.
// Assumes the package defaults, one instance and exact small-integer arithmetic.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import nn_mac_pkg::*;
;
    localparam int PASS_CYC = 16 * DEF_MAC_LAT + 1;
    logic clk, rst, psel, pen, pwr, pready, perr, sready, done, sat;
    logic we, tmo;
    logic [0:0] inst;
    logic [4:0] idx;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [DEF_SHELL_W-1:0] sdata;
    logic [ROW_BITS-1:0] srd;
    logic [8:0] cfgs[3] = '{9'h159, 9'h100, 9'h0ff};
    int bad_count, checked;
    int w[16][16], x[16], b[16], nb[16];

    nn_mac_array dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(perr), .I_SHELL_WE(we), .I_SHELL_INST(inst),
        .I_SHELL_IDX(idx), .I_SHELL_DATA(sdata), .O_SHELL_READY(sready),
        .O_SHELL_RDATA(srd), .O_DONE(done), .O_SAT(sat));
    shell_engine eng_u (.i_clk(clk), .i_ready(sready), .i_rdata(srd), .o_we(we),
        .o_inst(inst), .o_idx(idx), .o_data(sdata), .o_tmo(tmo));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic cmp_vec(input logic [ROW_BITS-1:0] g, input logic [ROW_BITS-1:0] e);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        cmp_vec(ROW_BITS'(g), ROW_BITS'(e));
    endtask

    task automatic cmp_bit(input logic g, input logic e);
        cmp_vec(ROW_BITS'(g), ROW_BITS'(e));
    endtask

    task automatic tally_and_finish();
        cmp_bit(tmo, 1'b0);
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Exact bfloat16 of a small integer
    function automatic logic [15:0] bf(input int v);
        int a, e;
        logic [15:0] r;
        a = (v < 0) ? -v : v;
        e = 0;
        r = 16'h0000;
        if (a == 0)
            return r;
        while ((a >> (e + 1)) != 0)
            e++;
        r[15] = (v < 0);
        r[14:7] = 8'(127 + e);
        r[6:0] = 7'((a << (7 - e)) & 127);
        return r;
    endfunction

    function automatic logic [ROW_BITS-1:0] expect_vec(input logic [8:0] cfg);
        logic [ROW_BITS-1:0] v;
        int s;
        v = '0;
        for (int r = 0; r <= int'(cfg[7:4]); r++)
        begin
            s = b[r];
            for (int c = 0; c <= int'(cfg[3:0]); c++)
                s += w[r][c] * x[c];
            if (cfg[8] && s < 0)
                s = 0;
            v[16*r +: 16] = bf(s);
        end
        return v;
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20)
        begin
            bad_count++;
            tally_and_finish();
        end
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Signed values keep every sum odd, so no zero sign ambiguity
    task automatic fill();
        for (int r = 0; r < 16; r++)
        begin
            x[r] = int'($urandom_range(2)) - 1;
            b[r] = 2 * int'($urandom_range(3)) - 3;
            for (int c = 0; c < 16; c++)
                w[r][c] = 2 * int'($urandom_range(2)) - 2;
        end
    endtask

    // Node sums of the loaded operands, with the activation if asked
    task automatic node_sums(input logic relu);
        for (int r = 0; r < 16; r++)
        begin
            nb[r] = b[r];
            for (int c = 0; c < 16; c++)
                nb[r] += w[r][c] * x[c];
            if (relu && nb[r] < 0)
                nb[r] = 0;
        end
    endtask

    task automatic load_all(input logic inf0);
        logic [DEF_SHELL_W-1:0] d;
        for (int k = 0; k < 8; k++)
        begin
            d = '0;
            for (int c = 0; c < 16; c++)
            begin
                d[16*c +: 16] = bf(w[2*k][c]);
                d[256 + 16*c +: 16] = bf(w[2*k+1][c]);
            end
            eng_u.load(5'(k), d);
        end
        d = '0;
        for (int c = 0; c < 16; c++)
            d[16*c +: 16] = bf(x[c]);
        if (inf0)
            d[15:0] = 16'h7f80;
        eng_u.load(SH_IDX_INPUT, d);
        d = '0;
        for (int c = 0; c < 16; c++)
            d[16*c +: 16] = bf(b[c]);
        eng_u.load(SH_IDX_BIAS, d);
    endtask

    task automatic run_pass(input logic probe, input logic [31:0] cfg);
        int n;
        apb(1'b1, ADDR_STATUS, 32'h6);
        // The clear lands on the ready edge, so look one edge later
        @(posedge clk);
        cmp_bit(done, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        if (probe)
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            cmp32(rd & 32'h1, 32'h1);
            cmp_bit(sready, 1'b0);
            apb(1'b1, ADDR_CONFIG, 32'h0ff);
            apb(1'b0, ADDR_CONFIG, 32'h0);
            cmp32(rd, cfg);
        end
        n = 0;
        while (done !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        if (!probe)
            cmp_bit(n >= PASS_CYC && n <= PASS_CYC + 2, 1'b1);
        cmp_bit(done, 1'b1);
    endtask

    task automatic chk_out(input logic [8:0] cfg);
        logic [ROW_BITS-1:0] v;
        logic [ROW_BITS-1:0] e;
        e = expect_vec(cfg);
        eng_u.fetch(1'b0, v);
        cmp_vec(v, e);
        for (int n = 0; n < 8; n++)
        begin
            apb(1'b0, ADDR_OUT_BASE + 12'(4 * n), 32'h0);
            cmp32(rd, e[32*n +: 32]);
        end
        apb(1'b0, ADDR_VALID, 32'h0);
        cmp32(rd, 32'((1 << (int'(cfg[7:4]) + 1)) - 1));
    endtask

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        bad_count = 0;
        checked = 0;
        void'($urandom(87));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, ADDR_CONFIG, 32'h0);
        cmp32(rd, 32'h0ff);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp32(rd, 32'h0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        cmp32(rd, 32'h0);
        apb(1'b0, 12'h3fc, 32'h0);
        cmp32({rd[30:0], perr}, 32'h1);
        $display("test reset done");
        for (int t = 0; t < 3; t++)
        begin
            fill();
            load_all(1'b0);
            apb(1'b1, ADDR_CONFIG, 32'(cfgs[t]));
            run_pass(t == 0, 32'(cfgs[t]));
            chk_out(cfgs[t]);
        end
        $display("test utilisation done");
        node_sums(1'b0);
        fill();
        b = nb;
        load_all(1'b0);
        run_pass(1'b0, 32'h0);
        chk_out(9'h0ff);
        $display("test chaining done");
        fill();
        load_all(1'b1);
        run_pass(1'b0, 32'h0);
        cmp_bit(sat, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp32(rd, 32'h6);
        apb(1'b1, ADDR_STATUS, 32'h4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp32(rd, 32'h2);
        cmp_bit(sat, 1'b0);
        load_all(1'b0);
        apb(1'b1, ADDR_CONFIG, 32'h1ff);
        run_pass(1'b0, 32'h0);
        cmp_bit(sat, 1'b0);
        chk_out(9'h1ff);
        $display("test saturation done");
        node_sums(1'b1);
        fill();
        x = nb;
        load_all(1'b0);
        apb(1'b1, ADDR_CONFIG, 32'h0f0);
        run_pass(1'b0, 32'h0);
        chk_out(9'h0f0);
        $display("test layer chaining done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
